/* core/tlp_cfg.svh */
// Constants for the transmit list processor: offsets, fields, codes.
// Assumes byte addressed host memory reached in 16-bit words.
//
// Functional notes
// - Refuse a request when not opened, already busy, or pointer is odd.
// - First list address is 24 bits; top byte of high word ignored.
// - List layout: link, control, length, three segments, handle.
// - Odd link marks last list; finish only after its frame is sent; code completes without waiting if that list's end bit is clear.
// - Follow an even link rewritten late; never write the link.
// - Valid bit checked only on an anticipated frame-start list.
// - Notify bit on start list raises notice once frame is sent.
// - Pass-CRC bit: last four data bytes go out as the CRC.
// - Pass-source bit: host source address is sent unchanged.
// - Bits 8-10 give frame kind; nonzero kind needs link control on.
// - After a frame: clear valid, set complete, copy bits 2,3,4,6,7.
// - Status words of non-start lists are never written.
// - Error sets bit 5 and code in 15:8; else returned status byte.
// - Codes for length, station, routing, kind and I frame outcomes.
// - Total length counts host bytes; must be nonzero in every list.
// - Up to three segments; a clear more flag ends; third ignores it.
// - Segment pointers are 24-bit, even or odd; top byte ignored.
// - Routing bit set when header length exceeds 14; not for I frames.
// - Invalid frame-start list suspends silently until revalidate.
`ifndef TLP_CFG_SVH
`define TLP_CFG_SVH
`define TLP_A_CTRL 8'h00
`define TLP_A_PARM0 8'h04
`define TLP_A_PARM1 8'h08
`define TLP_A_CMD 8'h0C
`define TLP_A_STAT 8'h10
`define TLP_A_LAST 8'h14
`define TLP_C_OPEN 0
`define TLP_C_LLC 1
`define TLP_K_GO 0
`define TLP_K_REVAL 1
`define TLP_W_LINKHI 4'h0
`define TLP_W_LINKLO 4'h1
`define TLP_W_CTRL 4'h2
`define TLP_W_LEN 4'h3
`define TLP_W_SEG0 4'h4
`define TLP_W_STN 4'hD
`define TLP_W_LAST 4'hE
`define TLP_SEG_LAST 2'h2
`define TLP_SEG_MORE 15
`define TLP_B_VALID 0
`define TLP_B_DONE 1
`define TLP_B_START 2
`define TLP_B_END 3
`define TLP_B_NOTE 4
`define TLP_B_ERR 5
`define TLP_B_CRC 6
`define TLP_B_SRC 7
`define TLP_STEP 24'h00_0002
`define TLP_STAT_OFS 24'h00_0004
`define TLP_HDR_ROUTE 8'h0E
`define TLP_HDR_MAX 8'h20
`define TLP_E_XMIT 8'h23
`define TLP_E_LEN 8'h28
`define TLP_E_STN 8'h40
`define TLP_E_ROUTE 8'h44
`define TLP_E_KIND 8'hF0
`define TLP_E_INOTRDY 8'hFE
`define TLP_E_IRDY 8'hFF
`define TLP_K_DIRECT 3'h0
`define TLP_K_IFRAME 3'h6
`define TLP_K_BAD 3'h7
`endif

/* core/tlp_pkg.sv */
// Types for the transmit list processor.
// Assumes tlp_cfg.svh holds the numeric constants.
package tlp_pkg;
  typedef enum logic [3:0] {
    TLP_IDLE = 4'h0,
    TLP_FETCH = 4'h1,
    TLP_CHECK = 4'h3,
    TLP_SEG = 4'h2,
    TLP_ENDL = 4'h6,
    TLP_WAITTX = 4'h7,
    TLP_WRSTAT = 4'h5,
    TLP_LINK = 4'h4,
    TLP_SUSPEND = 4'hC
  } tlp_state_t;
endpackage

/* core/tlp_list_proc.sv */
// Transmit list processor: walks host parameter lists and gathers data.
// Assumes a one-word memory port with ack, and a byte sink with ready.
//
// Our own choices: the APB slave port and the register offsets.
`include "tlp_cfg.svh"

module tlp_list_proc import tlp_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host memory port
  output logic memReq,
  output logic memWe,
  output logic [23:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic memAck,
  input wire logic [15:0] memRdata,
  // Frame byte stream
  output logic txValid,
  output logic [7:0] txByte,
  output logic txLast,
  input wire logic txReady,
  // Frame attributes
  output logic [2:0] frameKind,
  output logic passCrc,
  output logic passSrc,
  output logic setRoute,
  output logic [15:0] senderStationHandle,
  output logic [7:0] destinationAccessPoint,
  // Link outcome
  input wire logic txDone,
  input wire logic txFail,
  input wire logic [7:0] returnedStatusByte,
  input wire logic linkReady,
  // Events
  output logic frameNotify,
  output logic cmdComplete,
  output logic cmdReject
);

  function automatic logic [3:0] segBase(input logic [1:0] s);
    segBase = `TLP_W_SEG0 + {1'b0, s, 1'b0} + {2'b00, s};
  endfunction

  function automatic logic [23:0] ptr24(input logic [15:0] hi,
                                        input logic [15:0] lo);
    ptr24 = {hi[7:0], lo};
  endfunction

  tlp_state_t state;
  logic [15:0] listWord [0:14];
  logic [3:0] fetchIdx;
  logic linkOnly;
  logic relinked;
  logic anticipate;
  logic [23:0] listAddr;
  logic [23:0] startAddr;
  logic [23:0] lastList;
  logic [15:0] reqCtrl;
  logic [15:0] totalLen;
  logic [15:0] byteCnt;
  logic [1:0] segIdx;
  logic segLoaded;
  logic segMore;
  logic [15:0] segRem;
  logic [23:0] segPtr;
  logic errFlag;
  logic [7:0] errCode;
  logic opened;
  logic llcEnable;
  logic [15:0] hostParamWord0;
  logic [15:0] hostParamWord1;
  logic goPulse;
  logic revalPulse;
  logic apbAccess;
  logic [15:0] ctrlNow;
  logic [15:0] stnNow;
  logic [2:0] kindNow;
  logic [7:0] hdrNow;

  assign apbAccess = psel && penable && !pready;
  assign ctrlNow = listWord[`TLP_W_CTRL];
  assign stnNow = listWord[`TLP_W_STN];
  assign kindNow = ctrlNow[10:8];
  assign hdrNow = listWord[`TLP_W_LAST][7:0];

  // ------------------------------------------------------------
  // APB registers
  // ------------------------------------------------------------
  // Answer one cycle into the access phase; writes land with pready.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      opened <= 1'b0;
      llcEnable <= 1'b0;
      hostParamWord0 <= 16'h0000;
      hostParamWord1 <= 16'h0000;
      goPulse <= 1'b0;
      revalPulse <= 1'b0;
    end else begin
      pready <= apbAccess;
      goPulse <= 1'b0;
      revalPulse <= 1'b0;
      if (apbAccess) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        unique case (paddr)
          `TLP_A_CTRL: prdata <= {30'h0, llcEnable, opened};
          `TLP_A_PARM0: prdata <= {16'h0000, hostParamWord0};
          `TLP_A_PARM1: prdata <= {16'h0000, hostParamWord1};
          `TLP_A_CMD: prdata <= 32'h0000_0000;
          `TLP_A_STAT: prdata <= {30'h0, state == TLP_SUSPEND,
                                  state != TLP_IDLE};
          `TLP_A_LAST: prdata <= {8'h00, lastList};
          default: pslverr <= 1'b1;
        endcase
      end
      if (psel && penable && pready && pwrite) begin
        unique case (paddr)
          `TLP_A_CTRL: begin
            opened <= pwdata[`TLP_C_OPEN];
            llcEnable <= pwdata[`TLP_C_LLC];
          end
          `TLP_A_PARM0: hostParamWord0 <= pwdata[15:0];
          `TLP_A_PARM1: hostParamWord1 <= pwdata[15:0];
          `TLP_A_CMD: begin
            goPulse <= pwdata[`TLP_K_GO];
            revalPulse <= pwdata[`TLP_K_REVAL];
          end
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // List walker
  // ------------------------------------------------------------
  // No list lookahead: one list at a time keeps self links harmless.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= TLP_IDLE;
      for (int i = 0; i < 15; i++) begin
        listWord[i] <= 16'h0000;
      end
      fetchIdx <= 4'h0;
      linkOnly <= 1'b0;
      relinked <= 1'b0;
      anticipate <= 1'b0;
      listAddr <= 24'h00_0000;
      startAddr <= 24'h00_0000;
      lastList <= 24'h00_0000;
      reqCtrl <= 16'h0000;
      totalLen <= 16'h0000;
      byteCnt <= 16'h0000;
      segIdx <= 2'h0;
      segLoaded <= 1'b0;
      segMore <= 1'b0;
      segRem <= 16'h0000;
      segPtr <= 24'h00_0000;
      errFlag <= 1'b0;
      errCode <= 8'h00;
      memReq <= 1'b0;
      memWe <= 1'b0;
      memAddr <= 24'h00_0000;
      memWdata <= 16'h0000;
      txValid <= 1'b0;
      txByte <= 8'h00;
      txLast <= 1'b0;
      frameKind <= 3'h0;
      passCrc <= 1'b0;
      passSrc <= 1'b0;
      setRoute <= 1'b0;
      senderStationHandle <= 16'h0000;
      destinationAccessPoint <= 8'h00;
      frameNotify <= 1'b0;
      cmdComplete <= 1'b0;
      cmdReject <= 1'b0;
    end else begin
      frameNotify <= 1'b0;
      cmdComplete <= 1'b0;
      cmdReject <= 1'b0;
      if (txValid && txReady) begin
        txValid <= 1'b0;
      end
      // Second request while a chain runs is refused, walker untouched
      if (goPulse && state != TLP_IDLE) begin
        cmdReject <= 1'b1;
      end
      unique case (state)
        TLP_IDLE: begin
          if (goPulse) begin
            if (!opened || hostParamWord1[0]) begin
              cmdReject <= 1'b1;
            end else begin
              listAddr <= ptr24(hostParamWord0, hostParamWord1);
              memAddr <= ptr24(hostParamWord0, hostParamWord1);
              memReq <= 1'b1;
              memWe <= 1'b0;
              fetchIdx <= 4'h0;
              linkOnly <= 1'b0;
              relinked <= 1'b0;
              anticipate <= 1'b1;
              state <= TLP_FETCH;
            end
          end
        end
        TLP_FETCH: begin
          if (memAck) begin
            listWord[fetchIdx] <= memRdata;
            memReq <= 1'b0;
            if (fetchIdx == (linkOnly ? `TLP_W_LINKLO : `TLP_W_LAST)) begin
              state <= linkOnly ? TLP_LINK : TLP_CHECK;
            end else begin
              fetchIdx <= fetchIdx + 4'h1;
              memAddr <= memAddr + `TLP_STEP;
              memReq <= 1'b1;
            end
          end
        end
        TLP_CHECK: begin
          segIdx <= 2'h0;
          segLoaded <= 1'b0;
          if (anticipate && !ctrlNow[`TLP_B_VALID]) begin
            state <= TLP_SUSPEND;
          end else begin
            state <= TLP_SEG;
            if (listWord[`TLP_W_LEN] == 16'h0000 && !errFlag) begin
              errFlag <= 1'b1;
              errCode <= `TLP_E_LEN;
            end
            if (anticipate) begin
              anticipate <= 1'b0;
              startAddr <= listAddr;
              reqCtrl <= ctrlNow;
              totalLen <= listWord[`TLP_W_LEN];
              byteCnt <= 16'h0000;
              passCrc <= ctrlNow[`TLP_B_CRC];
              passSrc <= ctrlNow[`TLP_B_SRC];
              frameKind <= llcEnable ? kindNow : 3'h0;
              senderStationHandle <= stnNow;
              destinationAccessPoint <= (kindNow == `TLP_K_IFRAME) ? 8'h00
                : listWord[`TLP_W_LAST][15:8];
              setRoute <= (hdrNow > `TLP_HDR_ROUTE)
                && (kindNow != `TLP_K_IFRAME);
              errFlag <= 1'b1;
              if (kindNow == `TLP_K_BAD
                  || (kindNow != `TLP_K_DIRECT && !llcEnable)) begin
                errCode <= `TLP_E_KIND;
              end else if (listWord[`TLP_W_LEN] == 16'h0000) begin
                errCode <= `TLP_E_LEN;
              end else if (kindNow != `TLP_K_DIRECT
                           && stnNow == 16'h0000) begin
                errCode <= `TLP_E_STN;
              end else if (kindNow != `TLP_K_IFRAME
                           && hdrNow > `TLP_HDR_MAX) begin
                errCode <= `TLP_E_ROUTE;
              end else begin
                errFlag <= 1'b0;
                errCode <= 8'h00;
              end
            end
          end
        end
        TLP_SEG: begin
          if (!segLoaded) begin
            segLoaded <= 1'b1;
            segRem <= {1'b0, listWord[segBase(segIdx)][14:0]};
            segMore <= listWord[segBase(segIdx)][`TLP_SEG_MORE]
              && segIdx != `TLP_SEG_LAST;
            segPtr <= ptr24(listWord[segBase(segIdx) + 4'h1],
                            listWord[segBase(segIdx) + 4'h2]);
          end else if (segRem == 16'h0000) begin
            if (segMore) begin
              segIdx <= segIdx + 2'h1;
              segLoaded <= 1'b0;
            end else begin
              state <= TLP_ENDL;
            end
          end else if (memAck) begin
            memReq <= 1'b0;
            txValid <= 1'b1;
            txByte <= segPtr[0] ? memRdata[7:0] : memRdata[15:8];
            txLast <= (byteCnt + 16'h0001) == totalLen;
            byteCnt <= byteCnt + 16'h0001;
            segPtr <= segPtr + 24'h00_0001;
            segRem <= segRem - 16'h0001;
          end else if (!memReq && !txValid) begin
            memReq <= 1'b1;
            memWe <= 1'b0;
            memAddr <= {segPtr[23:1], 1'b0};
          end
        end
        TLP_ENDL: begin
          if (!txValid) begin
            state <= ctrlNow[`TLP_B_END] ? TLP_WAITTX : TLP_LINK;
          end
        end
        TLP_WAITTX: begin
          if (txDone) begin
            state <= TLP_WRSTAT;
            memReq <= 1'b1;
            memWe <= 1'b1;
            memAddr <= startAddr + `TLP_STAT_OFS;
            memWdata <= {returnedStatusByte, reqCtrl[`TLP_B_SRC],
                         reqCtrl[`TLP_B_CRC], 1'b0, reqCtrl[`TLP_B_NOTE],
                         reqCtrl[`TLP_B_END], reqCtrl[`TLP_B_START],
                         1'b1, 1'b0};
            if (errFlag) begin
              memWdata[15:8] <= errCode;
              memWdata[`TLP_B_ERR] <= 1'b1;
            end else if (byteCnt != totalLen) begin
              memWdata[15:8] <= `TLP_E_LEN;
              memWdata[`TLP_B_ERR] <= 1'b1;
            end else if (txFail) begin
              memWdata[15:8] <= `TLP_E_XMIT;
              memWdata[`TLP_B_ERR] <= 1'b1;
            end else if (frameKind == `TLP_K_IFRAME) begin
              memWdata[15:8] <= linkReady ? `TLP_E_IRDY
                : `TLP_E_INOTRDY;
              memWdata[`TLP_B_ERR] <= 1'b1;
            end
          end
        end
        TLP_WRSTAT: begin
          if (memAck) begin
            memReq <= 1'b0;
            memWe <= 1'b0;
            frameNotify <= reqCtrl[`TLP_B_NOTE];
            lastList <= startAddr;
            anticipate <= 1'b1;
            errFlag <= 1'b0;
            state <= TLP_LINK;
          end
        end
        TLP_LINK: begin
          if (!listWord[`TLP_W_LINKLO][0]) begin
            listAddr <= ptr24(listWord[`TLP_W_LINKHI],
                              listWord[`TLP_W_LINKLO]);
            memAddr <= ptr24(listWord[`TLP_W_LINKHI],
                             listWord[`TLP_W_LINKLO]);
            memReq <= 1'b1;
            fetchIdx <= 4'h0;
            linkOnly <= 1'b0;
            relinked <= 1'b0;
            state <= TLP_FETCH;
          end else if (relinked || anticipate == 1'b0) begin
            cmdComplete <= relinked;
            state <= relinked ? TLP_IDLE : TLP_LINK;
            relinked <= 1'b1;
          end else begin
            memAddr <= listAddr;
            memReq <= 1'b1;
            fetchIdx <= 4'h0;
            linkOnly <= 1'b1;
            relinked <= 1'b1;
            state <= TLP_FETCH;
          end
        end
        TLP_SUSPEND: begin
          if (revalPulse) begin
            memAddr <= listAddr;
            memReq <= 1'b1;
            fetchIdx <= 4'h0;
            linkOnly <= 1'b0;
            state <= TLP_FETCH;
          end
        end
        default: state <= TLP_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_reject;
    @(posedge core_clk) disable iff (sys_rst)
      goPulse && state != TLP_IDLE |=> cmdReject && !cmdComplete;
  endproperty
  a_reject: assert property (p_reject)
    else $error("busy request disturbed the walker");

  property p_firstAddr;
    @(posedge core_clk) disable iff (sys_rst)
      state == TLP_IDLE && goPulse && opened && !hostParamWord1[0] |=>
      listAddr == {$past(hostParamWord0[7:0]), $past(hostParamWord1)};
  endproperty
  a_firstAddr: assert property (p_firstAddr)
    else $error("first list address wrong");

  property p_statWord;
    @(posedge core_clk) disable iff (sys_rst)
      memReq && memWe |-> memWdata[`TLP_B_DONE] && !memWdata[`TLP_B_VALID]
      && memWdata[`TLP_B_START] == reqCtrl[`TLP_B_START];
  endproperty
  a_statWord: assert property (p_statWord)
    else $error("status word bits wrong");

  property p_statAddr;
    @(posedge core_clk) disable iff (sys_rst)
      memReq && memWe |-> memAddr == startAddr + `TLP_STAT_OFS;
  endproperty
  a_statAddr: assert property (p_statAddr)
    else $error("write outside start list status word");

  property p_suspend;
    @(posedge core_clk) disable iff (sys_rst)
      state == TLP_SUSPEND && !revalPulse |=> state == TLP_SUSPEND
      && !memReq && !frameNotify;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("left suspend without revalidate");

  property p_ascend;
    @(posedge core_clk) disable iff (sys_rst)
      state == TLP_FETCH && memAck && state == $past(state) |=>
      state != TLP_FETCH || (fetchIdx == $past(fetchIdx) + 4'h1
      && memAddr == $past(memAddr) + `TLP_STEP);
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("list words not fetched in order");

  property p_notify;
    @(posedge core_clk) disable iff (sys_rst)
      state == TLP_WRSTAT && memAck |=> frameNotify == reqCtrl[`TLP_B_NOTE]
      ##1 !frameNotify;
  endproperty
  a_notify: assert property (p_notify)
    else $error("frame notice wrong");

  property p_errCode;
    @(posedge core_clk) disable iff (sys_rst)
      state == TLP_WAITTX && txDone && errFlag |=>
      memWdata[`TLP_B_ERR] && memWdata[15:8] == $past(errCode);
  endproperty
  a_errCode: assert property (p_errCode)
    else $error("error code not reported");

  property p_segAddr;
    @(posedge core_clk) disable iff (sys_rst)
      state == TLP_SEG && memReq |-> memAddr == {segPtr[23:1], 1'b0};
  endproperty
  a_segAddr: assert property (p_segAddr)
    else $error("segment word address wrong");

endmodule

/* verif/tlp_host_mem.sv */
// Host memory model for the transmit list processor bench.
// Assumes one request at a time, held until acknowledged.
module tlp_host_mem (
  // Clock
  input wire logic core_clk,
  // Memory port
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [23:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic memAck,
  output logic [15:0] memRdata,
  // Pacing
  input wire logic [3:0] ackDelay
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Storage, word per even byte pair
  // ----------------------------------------
  logic [15:0] mem [0:255];
  logic [23:0] rdLog [$];
  logic [3:0] waitCnt = 4'h0;
  initial memAck = 1'b0;
  initial memRdata = 16'h0000;
  always @(posedge core_clk) begin
    memAck <= 1'b0;
    // Released bus toggles, so a stale word never looks valid
    memRdata <= ~memRdata;
    if (memReq && !memAck) begin
      if (waitCnt < ackDelay) begin
        waitCnt <= waitCnt + 4'h1;
      end else begin
        waitCnt <= 4'h0;
        memAck <= 1'b1;
        if (memWe) begin
          mem[memAddr[8:1]] <= memWdata;
        end else begin
          memRdata <= mem[memAddr[8:1]];
          rdLog.push_back(memAddr);
        end
      end
    end
  end
endmodule

/* verif/tlp_list_proc_tb_top.sv */
// Bench for the transmit list processor: APB driver, byte sink, link stub.
// Assumes tlp_host_mem answers the memory port.
`include "tlp_cfg.svh"
module tlp_list_proc_tb_top import tlp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, memReq, memWe, memAck, txValid, txLast, err;
  logic [23:0] memAddr;
  logic [15:0] memWdata, memRdata, senderStationHandle;
  logic [7:0] txByte, destinationAccessPoint;
  logic txReady = 1'b0, txDone = 1'b0, txFail = 1'b0, linkReady = 1'b0;
  logic [7:0] returnedStatusByte = 8'h00;
  logic [2:0] frameKind;
  logic passCrc, passSrc, setRoute, frameNotify, cmdComplete, cmdReject;
  logic [3:0] ackDelay = 4'h3;
  logic [8:0] rx [$];
  int numErrors = 0, testsRun = 0, notes = 0, dones = 0, rejects = 0;
  int cyc = 0, n;

  tlp_list_proc dut (.*);
  tlp_host_mem host (.*);

  initial forever #10 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    // Sink stalls one cycle in three
    txReady <= (cyc % 3) != 0;
    if (txValid === 1'b1 && txReady === 1'b1) rx.push_back({txLast, txByte});
    if (frameNotify === 1'b1) notes <= notes + 1;
    if (cmdComplete === 1'b1) dones <= dones + 1;
    if (cmdReject === 1'b1) rejects <= rejects + 1;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic endOfTest();
    $display("Counts: %0d checks, %0d mismatches", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(ref int k);
    @(posedge core_clk);
    k++;
    if (k > 3000) begin
      numErrors++;
      $display("Error wait expected done seen timeout");
      endOfTest();
    end
  endtask

  // Called just after a rising edge; holds request until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    tick(k);
    while (pready !== 1'b1) tick(k);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic putList(input int b, input logic [15:0] w [15]);
    foreach (w[i]) host.mem[b + i] = w[i];
  endtask

  task automatic getBytes(input logic [7:0] b [$]);
    n = 0;
    while (rx.size() < b.size()) tick(n);
    foreach (b[i]) chk("frame byte", {23'h00_0000, rx[i]},
      {23'h00_0000, i == b.size() - 1, b[i]});
    rx.delete();
  endtask

  // Link holds done until the status write shows up
  task automatic linkDone(input logic [7:0] fs);
    returnedStatusByte <= fs;
    txDone <= 1'b1;
    n = 0;
    while (!(memReq === 1'b1 && memWe === 1'b1)) tick(n);
    txDone <= 1'b0;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    putList(32'h20, '{16'h0000, 16'h0080, 16'h00DD, 16'h0003, 16'h8002,
      16'hFF00, 16'h0101, 16'h0001, 16'h0000, 16'h0110, 16'h0000,
      16'h0000, 16'h0000, 16'h0001, 16'h0510});
    putList(32'h40, '{16'h0000, 16'h00C0, 16'h0704, 16'h0002, 16'h0001,
      16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0002, 16'h0510});
    putList(32'h60, '{16'h0000, 16'h0001, 16'h0008, 16'h0002, 16'h0001,
      16'h0000, 16'h0103, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000});
    putList(32'h70, '{16'h0000, 16'h0001, 16'h060D, 16'h0001, 16'h0001,
      16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0002, 16'h0510});
    host.mem[8'h80] = 16'h1122;
    host.mem[8'h81] = 16'h3344;
    host.mem[8'h88] = 16'h5566;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk("idle outputs", {27'h000_0000, memReq, txValid, frameNotify,
      cmdComplete, cmdReject}, 32'h0000_0000);
    apb(1'b0, `TLP_A_STAT, 32'h0000_0000);
    chk("status", rd, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", {31'h0000_0000, err}, 32'h0000_0001);
    $display("Test reset done");
    apb(1'b1, `TLP_A_PARM0, 32'h0000_1200);
    apb(1'b1, `TLP_A_PARM1, 32'h0000_0040);
    apb(1'b1, `TLP_A_CMD, 32'h0000_0001);
    repeat (6) @(posedge core_clk);
    chk("reject closed", rejects, 32'h0000_0001);
    apb(1'b1, `TLP_A_CTRL, 32'h0000_0001);
    apb(1'b1, `TLP_A_PARM1, 32'h0000_0041);
    apb(1'b1, `TLP_A_CMD, 32'h0000_0001);
    repeat (6) @(posedge core_clk);
    chk("reject odd", rejects, 32'h0000_0002);
    $display("Test refusals done");
    apb(1'b1, `TLP_A_PARM1, 32'h0000_0040);
    apb(1'b1, `TLP_A_CMD, 32'h0000_0001);
    getBytes('{8'h22, 8'h33, 8'h55});
    chk("attributes", {26'h000_0000, passCrc, passSrc, setRoute, frameKind},
      32'h0000_0038);
    chk("handle", {senderStationHandle, destinationAccessPoint},
      32'h0000_0105);
    linkDone(8'h5A);
    n = 0;
    while (notes < 1) tick(n);
    chk("start status", host.mem[8'h22], 32'h0000_5ADE);
    for (int i = 0; i < 15; i++) chk("fetch order", {8'h00, host.rdLog[i]},
      {8'h00, 24'h00_0040 + 24'(2 * i)});
    $display("Test first frame done");
    rd = 32'h0000_0000;
    n = 0;
    while (rd[1] !== 1'b1) begin
      apb(1'b0, `TLP_A_STAT, 32'h0000_0000);
      tick(n);
    end
    chk("suspended busy", rd, 32'h0000_0003);
    apb(1'b1, `TLP_A_CMD, 32'h0000_0001);
    repeat (6) @(posedge core_clk);
    chk("reject busy", rejects, 32'h0000_0003);
    host.mem[8'h42] = 16'h0705;
    ackDelay <= 4'h0;
    apb(1'b1, `TLP_A_CMD, 32'h0000_0002);
    getBytes('{8'h11, 8'h44});
    chk("kind off", frameKind, 32'h0000_0000);
    linkDone(8'h00);
    n = 0;
    while (dones < 1) tick(n);
    chk("error status", host.mem[8'h42], 32'h0000_F026);
    chk("tail status", host.mem[8'h62], 32'h0000_0008);
    chk("tail link", {host.mem[8'h60], host.mem[8'h61]},
      32'h0000_0001);
    chk("notices", notes, 32'h0000_0001);
    apb(1'b0, `TLP_A_STAT, 32'h0000_0000);
    chk("idle status", rd, 32'h0000_0000);
    apb(1'b0, `TLP_A_LAST, 32'h0000_0000);
    chk("last list", rd, 32'h0000_0080);
    $display("Test chain done");
    // I frame with link control on; top byte of high word must be ignored
    apb(1'b1, `TLP_A_CTRL, 32'h0000_0003);
    apb(1'b1, `TLP_A_PARM1, 32'h0000_00E0);
    linkReady <= 1'b1;
    apb(1'b1, `TLP_A_CMD, 32'h0000_0001);
    getBytes('{8'h11});
    chk("I attributes", {26'h000_0000, passCrc, passSrc, setRoute,
      frameKind}, 32'h0000_0006);
    chk("I handle", {senderStationHandle, destinationAccessPoint},
      32'h0000_0200);
    linkDone(8'h00);
    n = 0;
    while (dones < 2) tick(n);
    chk("I status", host.mem[8'h72], 32'h0000_FF2E);
    chk("I notices", notes, 32'h0000_0001);
    $display("Test I frame done");
    endOfTest();
  end
endmodule
